// *** rtl/ebcu_top.sv ***
// Purpose: Break-condition unit of an in-circuit emulator
// Assumes: All inputs synchronous to clk; host honours cmd_ready
// Notes: Range commands walk one address per cycle
// Overview of operation
// R1 - One breakpoint bit for every code address, mapped one to one.
// R2 - Memory address span depends on mode: 7DFH, 0FDFH or 7FFFH.
// R3 - A set bit arms a break at its address; a clear bit never breaks.
// R4 - Only the first byte of an executed instruction can raise a break.
// R5 - Breakpoint bits stop emulation only while their source is enabled.
// R6 - Six break-source enables, each set and cleared independently.
// R7 - After power-up the breakpoint and halt-entry enables are set.
// R8 - Whole-memory write clears to 0 without a value, else writes it.
// R9 - Single, range and whole writes apply in issue order; later wins.
// R10 - Code load with clear option zeroes only the loaded addresses.
// R11 - Host may read one address, a range or all, without change.
// R12 - Enabled probe source stops emulation on a probe low-to-high edge.
// R13 - Enabled halt source stops emulation when the chip enters halt.
// R14 - Any enabled source stops emulation and latches its cause code.
`timescale 1ns/1ps
module ebcu_top import ebcu_pkg::*; #(
  parameter int AW = ADDR_W
) (
  // Clock, reset, enable
  input logic clk,
  input logic rst_n,
  input logic ce,
  // Mode
  input logic [1:0] mode,
  // Host breakpoint memory commands
  input logic cmd_valid,
  output logic cmd_ready,
  input ebcu_op_t cmd_op,
  input logic [AW-1:0] cmd_lo,
  input logic [AW-1:0] cmd_hi,
  input logic cmd_has_data,
  input logic cmd_bit,
  output logic cmd_err,
  // Host read-back stream
  output logic rd_valid,
  output logic [AW-1:0] rd_addr,
  output logic rd_bit,
  // Break-source enable set
  input logic en_wr,
  input logic [NSRC-1:0] en_set,
  input logic [NSRC-1:0] en_clr,
  output logic bitmap_break_enable,
  output logic cycle_overflow_break_enable,
  output logic trace_full_break_enable,
  output logic pass_count_overflow_break_enable,
  output logic halt_entry_break_enable,
  output logic probe_pin_break_enable,
  // Emulation control
  input logic go,
  output logic running,
  output logic stop,
  output logic [2:0] break_cause,
  // Target events
  input logic [AW-1:0] pc,
  input logic fetch_first,
  input logic cycle_ovf,
  input logic trace_full,
  input logic pass_ovf,
  input logic halt_mode,
  input logic probe_in
);
  if (AW != ADDR_W) begin : g_chk
    $error("ebcu_top: address width must match the code space");
  end

  typedef enum logic {ST_IDLE, ST_WALK} ebcu_state_t;

  ebcu_state_t state;
  ebcu_state_t next_state;
  ebcu_op_t op;
  ebcu_op_t next_op;
  logic [AW-1:0] cur;
  logic [AW-1:0] next_cur;
  logic [AW-1:0] hi;
  logic [AW-1:0] next_hi;
  logic dat;
  logic next_dat;
  logic next_cmd_err;
  logic next_rd_valid;
  logic [AW-1:0] next_rd_addr;
  logic next_rd_bit;
  logic [AW-1:0] lim;
  logic take;
  logic ranged_ok;
  logic mem_wr;
  logic mem_wr_bit;
  logic fill_en;
  logic fill_bit;
  logic bit_a;
  logic bit_b;
  logic [NSRC-1:0] en;
  logic [NSRC-1:0] next_en;
  logic next_running;
  logic next_stop;
  logic [2:0] next_cause;
  logic bp_hit;
  logic halt_rise;
  logic probe_rise;
  logic [NSRC-1:0] fire;

  // Mode picks the top usable address (see R2)
  assign lim = limit_of(mode);
  assign cmd_ready = (state == ST_IDLE);
  assign take = ce & cmd_valid & cmd_ready;
  assign ranged_ok = (cmd_lo <= cmd_hi) && (cmd_hi <= lim);

  // Single and range writes come from the walker, whole fills only when idle, so issue order is kept (see R9)
  assign mem_wr = (state == ST_WALK) && (op == OP_WRITE || op == OP_LOAD_CLR);
  assign mem_wr_bit = (op == OP_LOAD_CLR) ? 1'b0 : dat; // see R10
  // Whole-memory write: no value given means clear (see R8)
  assign fill_en = take && (cmd_op == OP_WRITE_ALL);
  assign fill_bit = cmd_has_data & cmd_bit;

  ebcu_bitmap #(.AW(AW)) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr_en(mem_wr),
    .wr_addr(cur),
    .wr_bit(mem_wr_bit),
    .fill_en(fill_en),
    .fill_bit(fill_bit),
    .addr_a(pc),
    .bit_a(bit_a),
    .addr_b(cur),
    .bit_b(bit_b)
  );

  // Command walker: latch a command, then step one address per cycle
  always_comb begin
    next_state = state;
    next_op = op;
    next_cur = cur;
    next_hi = hi;
    next_dat = dat;
    next_cmd_err = 1'b0;
    next_rd_valid = 1'b0;
    next_rd_addr = rd_addr;
    next_rd_bit = rd_bit;
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          next_op = cmd_op;
          next_dat = cmd_bit;
          if (cmd_op == OP_READ_ALL) begin
            next_cur = '0; // see R11
            next_hi = lim;
            next_state = ST_WALK;
          end else if (cmd_op != OP_WRITE_ALL) begin
            next_cur = cmd_lo;
            next_hi = cmd_hi;
            if (ranged_ok) begin
              next_state = ST_WALK; // see R9
            end else begin
              next_cmd_err = 1'b1; // Out of mode span or reversed, see R2
            end
          end
        end
      end
      ST_WALK: begin
        if (op == OP_READ || op == OP_READ_ALL) begin
          next_rd_valid = 1'b1; // see R11
          next_rd_addr = cur;
          next_rd_bit = bit_b;
        end
        if (cur == hi) begin
          next_state = ST_IDLE;
        end else begin
          next_cur = cur + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      op <= OP_WRITE;
      cur <= '0;
      hi <= '0;
      dat <= 1'b0;
      cmd_err <= 1'b0;
      rd_valid <= 1'b0;
      rd_addr <= '0;
      rd_bit <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      op <= next_op;
      cur <= next_cur;
      hi <= next_hi;
      dat <= next_dat;
      cmd_err <= next_cmd_err;
      rd_valid <= next_rd_valid;
      rd_addr <= next_rd_addr;
      rd_bit <= next_rd_bit;
    end
  end

  // Edge detectors for halt entry and the probe pin
  ebcu_rise u_halt (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .level(halt_mode),
    .rise(halt_rise)
  );

  ebcu_rise u_probe (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .level(probe_in),
    .rise(probe_rise)
  );

  // Fetch path: only a first-byte fetch inside the mode span can hit
  assign bp_hit = fetch_first & bit_a & (pc <= lim); // see R3 see R4

  // Gate each source by its enable; only counted while running
  always_comb begin
    fire = '0;
    fire[SRC_BP] = bp_hit; // see R5
    fire[SRC_CC] = cycle_ovf;
    fire[SRC_TF] = trace_full;
    fire[SRC_AP] = pass_ovf;
    fire[SRC_PD] = halt_rise; // see R13
    fire[SRC_XP] = probe_rise; // see R12
    fire = fire & en & {NSRC{running}};
  end

  // Enable set, stop pulse and cause latch
  always_comb begin
    next_en = en;
    next_running = running;
    next_stop = 1'b0;
    next_cause = break_cause;
    if (en_wr) begin
      next_en = (en | en_set) & ~en_clr; // Clear wins when both, see R6
    end
    if (go) begin
      next_running = 1'b1;
    end
    if (|fire) begin
      next_running = 1'b0; // see R14
      next_stop = 1'b1;
      // Lowest source index wins when several fire together
      for (int i = NSRC - 1; i >= 0; i--) begin
        if (fire[i]) begin
          next_cause = 3'(i + 1);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en <= EN_RESET; // see R7
      running <= 1'b0;
      stop <= 1'b0;
      break_cause <= CAUSE_NONE;
    end else if (ce) begin
      en <= next_en;
      running <= next_running;
      stop <= next_stop;
      break_cause <= next_cause;
    end
  end

  assign bitmap_break_enable = en[SRC_BP];
  assign cycle_overflow_break_enable = en[SRC_CC];
  assign trace_full_break_enable = en[SRC_TF];
  assign pass_count_overflow_break_enable = en[SRC_AP];
  assign halt_entry_break_enable = en[SRC_PD];
  assign probe_pin_break_enable = en[SRC_XP];

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_bp_stops: assert property (ce && running && fetch_first && bit_a && en[SRC_BP] // see R3
      && pc <= lim |=> stop && break_cause == CAUSE_BP)
    else $error("breakpoint hit did not stop with its cause");
  a_bp_masked: assert property (ce && running && !en[SRC_BP] && (fire & 6'h3e) == '0 // see R5
      |=> !stop)
    else $error("stop without an enabled source");
  a_later_byte: assert property (ce && running && !fetch_first && (fire & 6'h3e) == '0 // see R4
      |=> !stop)
    else $error("break from a later instruction byte");
  a_walk_span: assert property (mem_wr |-> cur <= lim) // see R2
    else $error("breakpoint write outside mode span");
  a_fill_zero: assert property (take && cmd_op == OP_WRITE_ALL && !cmd_has_data // see R8
      |-> fill_en && !fill_bit ##1 !u_mem.mem[0])
    else $error("whole write without value did not clear");
  a_range_order: assert property (take && cmd_op == OP_WRITE && ranged_ok // see R9
      |=> !cmd_ready && cur == $past(cmd_lo))
    else $error("range write not started at its low address");
  a_ldclr_zero: assert property (mem_wr && op == OP_LOAD_CLR && ce // see R10
      |=> !$past(mem_wr_bit) && !u_mem.mem[$past(cur)])
    else $error("load clear left a bit set");
  a_read_keep: assert property (state == ST_WALK && (op == OP_READ || op == OP_READ_ALL) // see R11
      && ce |-> !mem_wr ##1 rd_valid && rd_addr == $past(cur))
    else $error("read disturbed memory or lost data");
  a_probe_stop: assert property (ce && running && probe_rise && en[SRC_XP] // see R12
      |=> stop && !running)
    else $error("probe edge did not stop emulation");
  a_halt_stop: assert property (ce && running && halt_rise && en[SRC_PD] // see R13
      |=> stop && !running)
    else $error("halt entry did not stop emulation");
  // Cause may only move at the edge that also raises the stop pulse
  a_cause_held: assert property (!stop // see R14
      |-> break_cause == $past(break_cause))
    else $error("cause changed without a new stop");

  c_bp_break: cover property (stop && break_cause == CAUSE_BP);
  c_probe_break: cover property (stop && break_cause == CAUSE_XP);
  c_read_all: cover property (take && cmd_op == OP_READ_ALL ##[1:40] rd_valid);
  c_range_write: cover property (take && cmd_op == OP_WRITE && cmd_lo != cmd_hi && ranged_ok);
endmodule

// *** rtl/ebcu_pkg.sv ***
// Purpose: Shared constants and types for the emulator break-condition unit
// Assumes: 15-bit code address space, one breakpoint bit per code address
// Notes: Cause codes are what the host reads back after a stop
package ebcu_pkg;
  // Code address width and per-mode top address of the breakpoint memory
  localparam int ADDR_W = 15;
  localparam logic [14:0] LIM_SMALL = 15'h07df;
  localparam logic [14:0] LIM_LARGE = 15'h0fdf;
  localparam logic [14:0] LIM_EXP = 15'h7fff;

  // Operating mode codes
  localparam logic [1:0] MODE_SMALL = 2'h0;
  localparam logic [1:0] MODE_LARGE = 2'h1;
  localparam logic [1:0] MODE_EXP = 2'h2;

  // Break source positions in the enable set
  localparam int NSRC = 6;
  localparam int SRC_BP = 0;
  localparam int SRC_CC = 1;
  localparam int SRC_TF = 2;
  localparam int SRC_AP = 3;
  localparam int SRC_PD = 4;
  localparam int SRC_XP = 5;
  localparam logic [5:0] EN_RESET = 6'h11;

  // Stop cause codes
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_BP = 3'h1;
  localparam logic [2:0] CAUSE_CC = 3'h2;
  localparam logic [2:0] CAUSE_TF = 3'h3;
  localparam logic [2:0] CAUSE_AP = 3'h4;
  localparam logic [2:0] CAUSE_PD = 3'h5;
  localparam logic [2:0] CAUSE_XP = 3'h6;

  // Host commands on the breakpoint memory
  typedef enum logic [2:0] {
    OP_WRITE, OP_WRITE_ALL, OP_READ, OP_READ_ALL, OP_LOAD_CLR
  } ebcu_op_t;

  // Top address of the breakpoint memory in a mode; unknown codes act as expanded
  function automatic logic [14:0] limit_of(input logic [1:0] mode);
    logic [14:0] lim;
    lim = LIM_EXP;
    if (mode == MODE_SMALL) begin
      lim = LIM_SMALL;
    end else if (mode == MODE_LARGE) begin
      lim = LIM_LARGE;
    end
    return lim;
  endfunction
endpackage

// *** rtl/ebcu_bitmap.sv ***
// Purpose: Breakpoint bit memory, one flip-flop per code address
// Assumes: Single writes and whole-memory fills never coincide
// Notes: Two combinational read ports, one for the fetch path, one for the host
`timescale 1ns/1ps
module ebcu_bitmap import ebcu_pkg::*; #(
  parameter int AW = ADDR_W
) (
  // Clock, reset, enable
  input logic clk,
  input logic rst_n,
  input logic ce,
  // Single-bit write and whole-memory fill
  input logic wr_en,
  input logic [AW-1:0] wr_addr,
  input logic wr_bit,
  input logic fill_en,
  input logic fill_bit,
  // Read ports
  input logic [AW-1:0] addr_a,
  output logic bit_a,
  input logic [AW-1:0] addr_b,
  output logic bit_b
);
  localparam int DEPTH = 2 ** AW;

  if (AW < 1 || AW > 16) begin : g_chk
    $error("ebcu_bitmap: address width out of range");
  end

  logic [DEPTH-1:0] mem;
  logic [DEPTH-1:0] next_mem;

  // One bit per code address, indexed directly by address (see R1)
  always_comb begin
    next_mem = mem;
    if (fill_en) begin
      next_mem = {DEPTH{fill_bit}};
    end else if (wr_en) begin
      next_mem[wr_addr] = wr_bit;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem <= '0;
    end else if (ce) begin
      mem <= next_mem;
    end
  end

  // Reads never disturb the contents (see R11)
  assign bit_a = mem[addr_a];
  assign bit_b = mem[addr_b];
endmodule

// *** rtl/ebcu_rise.sv ***
// Purpose: Rising-edge detector for a synchronous level
// Assumes: Input already synchronous to clk
// Notes: Output is a combinational one-cycle pulse
`timescale 1ns/1ps
module ebcu_rise (
  // Clock, reset, enable
  input logic clk,
  input logic rst_n,
  input logic ce,
  // Level in, pulse out
  input logic level,
  output logic rise
);
  logic prev;
  logic next_prev;

  // Previous sample; starts low so a level high out of reset counts once
  always_comb begin
    next_prev = level;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
    end else if (ce) begin
      prev <= next_prev;
    end
  end

  assign rise = level & ~prev;
endmodule

// *** verification/ebcu_target_model.sv ***
// Purpose: Target model that steps two-byte instructions while running
// Assumes: Every instruction is two bytes, first byte flagged
// Notes: A frozen pc is shown inverted so a stale address never looks live
`timescale 1ns/1ps
module ebcu_target_model import ebcu_pkg::*; (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Emulation control
  input logic go,
  input logic running,
  input logic [14:0] start_pc,
  // Fetch stream
  output logic [14:0] pc,
  output logic fetch_first
);
  logic [14:0] base;
  logic ph;
  logic [14:0] next_base;
  logic next_ph;
  // One byte per running cycle; go reloads the start address
  always_comb begin
    next_base = base;
    next_ph = ph;
    if (go) begin
      next_base = start_pc;
      next_ph = 1'b0;
    end else if (running) begin
      next_ph = ~ph;
      if (ph) begin
        next_base = base + 15'h0002;
      end
    end
  end
  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base <= 15'h0000;
      ph <= 1'b0;
    end else begin
      base <= next_base;
      ph <= next_ph;
    end
  end
  // Only the first byte of each instruction is flagged
  assign fetch_first = running & ~ph;
  assign pc = running ? (ph ? base + 15'h0001 : base) : ~base;
endmodule

// *** verification/tb_ebcu_top.sv ***
// Purpose: Self-checking bench for the break-condition unit
// Assumes: Inputs change 10 ns after the rising edge
// Notes: Expected memory is a plain array updated as commands are issued
`timescale 1ns/1ps
module tb_ebcu_top import ebcu_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, go = 1'b0, en_wr = 1'b0;
  logic [1:0] mode = MODE_EXP;
  logic cmd_valid = 1'b0, cmd_has_data = 1'b0, cmd_bit = 1'b0;
  logic cmd_ready, cmd_err, rd_valid, rd_bit, running, stop, fetch_first;
  ebcu_op_t cmd_op = OP_READ;
  logic [14:0] cmd_lo = 15'h0000, cmd_hi = 15'h0000, start_pc = 15'h0000;
  logic [14:0] rd_addr, pc, rd_next;
  logic [5:0] en_set = 6'h00, en_clr = 6'h00, evt = 6'h00, exp_en = 6'h11;
  logic [5:0] en_vec;
  logic [2:0] break_cause;
  logic exp_mem [0:32767];
  int n_fail = 0, n_compared = 0, cyc = 0, n_rd = 0;

  ebcu_top i_ebcu_top (.clk(clk), .rst_n(rst_n), .ce(ce), .mode(mode),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_lo(cmd_lo),
    .cmd_hi(cmd_hi), .cmd_has_data(cmd_has_data), .cmd_bit(cmd_bit), .cmd_err(cmd_err),
    .rd_valid(rd_valid), .rd_addr(rd_addr), .rd_bit(rd_bit), .en_wr(en_wr),
    .en_set(en_set), .en_clr(en_clr), .bitmap_break_enable(en_vec[0]),
    .cycle_overflow_break_enable(en_vec[1]), .trace_full_break_enable(en_vec[2]),
    .pass_count_overflow_break_enable(en_vec[3]), .halt_entry_break_enable(en_vec[4]),
    .probe_pin_break_enable(en_vec[5]), .go(go), .running(running), .stop(stop),
    .break_cause(break_cause), .pc(pc), .fetch_first(fetch_first), .cycle_ovf(evt[1]),
    .trace_full(evt[2]), .pass_ovf(evt[3]), .halt_mode(evt[4]), .probe_in(evt[5]));
  ebcu_target_model i_ebcu_target_model (.clk(clk), .rst_n(rst_n), .go(go),
    .running(running), .start_pc(start_pc), .pc(pc), .fetch_first(fetch_first));

  // Clock at 10 MHz
  always #50 clk = ~clk;

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard, well above the longest read-all walk
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      summarize();
    end
  end

  // Streamed read bits must come in ascending order and match the model
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      chk("rd_addr", 16'(rd_addr), 16'(rd_next));
      chk("rd_bit", 16'(rd_bit), 16'(exp_mem[rd_next]));
      rd_next = rd_next + 15'h0001;
      n_rd++;
    end
  end

  task automatic cmd(input ebcu_op_t op, input logic [14:0] lo, input logic [14:0] hi,
                     input logic has, input logic b);
    logic [14:0] lim;
    logic bad;
    int want;
    int walk;
    int k;
    lim = (mode == MODE_SMALL) ? LIM_SMALL : (mode == MODE_LARGE) ? LIM_LARGE : LIM_EXP;
    bad = (op != OP_WRITE_ALL && op != OP_READ_ALL) && (lo > hi || hi > lim);
    walk = (op == OP_READ_ALL) ? int'(lim) + 1 : (op != OP_WRITE_ALL && !bad) ? hi - lo + 1 : 0;
    want = (op == OP_READ || op == OP_READ_ALL) ? walk : 0;
    @(posedge clk);
    #10;
    cmd_op = op;
    cmd_lo = lo;
    cmd_hi = hi;
    cmd_has_data = has;
    cmd_bit = b;
    cmd_valid = 1'b1;
    rd_next = (op == OP_READ_ALL) ? 15'h0000 : lo;
    n_rd = 0;
    @(posedge clk);
    #10;
    cmd_valid = 1'b0;
    chk("cmd_err", 16'(cmd_err), 16'(bad));
    if (op == OP_WRITE_ALL) begin
      for (k = 0; k < 32768; k++) exp_mem[k] = has & b;
    end else if (!bad && (op == OP_WRITE || op == OP_LOAD_CLR)) begin
      for (k = lo; k <= hi; k++) exp_mem[k] = (op == OP_WRITE) & b;
    end
    k = 0;
    while (cmd_ready !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #10;
      k++;
    end
    chk("busy_cycles", 16'(k), 16'(walk));
    @(posedge clk);
    #10;
    chk("read_count", 16'(n_rd), 16'(want));
  endtask

  task automatic en(input logic [5:0] s, input logic [5:0] c);
    @(posedge clk);
    #10;
    en_wr = 1'b1;
    en_set = s;
    en_clr = c;
    @(posedge clk);
    #10;
    en_wr = 1'b0;
    exp_en = (exp_en | s) & ~c;
    chk("enables", 16'(en_vec), 16'(exp_en));
  endtask

  task automatic run(input logic [14:0] a);
    @(posedge clk);
    #10;
    start_pc = a;
    go = 1'b1;
    @(posedge clk);
    #10;
    go = 1'b0;
    chk("running", 16'(running), 16'h0001);
  endtask

  task automatic wait_stop(input int n, output logic got);
    got = 1'b0;
    for (int k = 0; k < n && !got; k++) begin
      @(posedge clk);
      #10;
      got = (stop === 1'b1);
    end
  endtask

  task automatic t_enables();
    for (int i = 0; i < 6; i++) en(6'(6'h01 << i), 6'h00);
    for (int i = 0; i < 6; i++) en(6'h00, 6'(6'h01 << i));
    en(6'h21, 6'h20);
    en(6'h11, 6'h2e);
    // A write while the clock enable is low must leave the set untouched
    @(posedge clk);
    #10;
    ce = 1'b0;
    en_wr = 1'b1;
    en_set = 6'h2e;
    en_clr = 6'h11;
    @(posedge clk);
    #10;
    en_wr = 1'b0;
    ce = 1'b1;
    chk("ce_freeze", 16'(en_vec), 16'(exp_en));
  endtask

  task automatic t_memory();
    logic [14:0] lims [4];
    lims = '{LIM_SMALL, LIM_LARGE, LIM_EXP, LIM_EXP};
    cmd(OP_WRITE, 15'h0105, 15'h0119, 1'b1, 1'b1);
    cmd(OP_WRITE, 15'h0108, 15'h0108, 1'b1, 1'b0);
    cmd(OP_WRITE, 15'h0120, 15'h0120, 1'b1, 1'b1);
    cmd(OP_READ, 15'h0100, 15'h0120, 1'b0, 1'b0);
    cmd(OP_READ, 15'h0120, 15'h0120, 1'b0, 1'b0);
    cmd(OP_WRITE_ALL, 15'h0000, 15'h0000, 1'b1, 1'b1);
    cmd(OP_LOAD_CLR, 15'h0100, 15'h011f, 1'b0, 1'b0);
    cmd(OP_READ, 15'h00f0, 15'h012f, 1'b0, 1'b0);
    cmd(OP_WRITE_ALL, 15'h0000, 15'h0000, 1'b0, 1'b1);
    cmd(OP_READ, 15'h00f0, 15'h00ff, 1'b0, 1'b0);
    for (int m = 0; m < 4; m++) begin
      mode = 2'(m);
      cmd(OP_READ, lims[m], lims[m], 1'b0, 1'b0);
      if (m < 2) begin
        cmd(OP_READ, lims[m] + 15'h0001, lims[m] + 15'h0001, 1'b0, 1'b0);
        cmd(OP_WRITE, lims[m] + 15'h0001, lims[m] + 15'h0001, 1'b1, 1'b1);
      end
      cmd(OP_READ, 15'h0010, 15'h000f, 1'b0, 1'b0);
    end
    mode = MODE_SMALL;
    cmd(OP_READ_ALL, 15'h0000, 15'h0000, 1'b0, 1'b0);
    mode = MODE_EXP;
  endtask

  task automatic t_breaks();
    logic got;
    int j;
    cmd(OP_WRITE, 15'h0201, 15'h0201, 1'b1, 1'b1);
    cmd(OP_WRITE, 15'h0204, 15'h0204, 1'b1, 1'b1);
    run(15'h0200);
    wait_stop(40, got);
    chk("bp_stop", 16'(got), 16'h0001);
    chk("bp_cause", 16'(break_cause), 16'(CAUSE_BP));
    chk("bp_addr", 16'(i_ebcu_target_model.base), 16'h0204);
    en(6'h20, 6'h01);
    run(15'h0200);
    wait_stop(20, got);
    chk("bp_masked", 16'(got), 16'h0000);
    // Remaining sources: a disabled one must not stop, the enabled one must
    for (int i = 1; i < 6; i++) begin
      en(6'(6'h01 << i), ~6'(6'h01 << i));
      j = (i == 5) ? 1 : i + 1;
      run(15'h0600);
      evt[j] = 1'b1;
      wait_stop(4, got);
      chk("src_masked", 16'(got), 16'h0000);
      evt[j] = 1'b0;
      evt[i] = 1'b1;
      wait_stop(4, got);
      chk("src_stop", 16'(got), 16'h0001);
      chk("src_cause", 16'(break_cause), 16'(i + 1));
      evt[i] = 1'b0;
      @(posedge clk);
      #10;
      chk("cause_held", 16'(break_cause), 16'(i + 1));
    end
  endtask

  // Main sequence
  initial begin
    for (int k = 0; k < 32768; k++) exp_mem[k] = 1'b0;
    repeat (10) @(posedge clk);
    #10;
    rst_n = 1'b1;
    chk("reset_enables", 16'(en_vec), 16'h0011);
    chk("reset_cause", 16'(break_cause), 16'(CAUSE_NONE));
    t_enables();
    t_memory();
    t_breaks();
    summarize();
  end
endmodule
